// file: verilog/tfl_pkg.sv
`default_nettype none
package tfl_pkg;
  typedef logic [7:0] tfl_byte_t;
  // -------------------------------------------------------
  // Register offsets
  // -------------------------------------------------------
  localparam tfl_byte_t ADDR_STATUS = 8'h02;
  localparam tfl_byte_t ADDR_FRAC = 8'h06;
  localparam tfl_byte_t ADDR_FAN_PERIOD = 8'h08;
  localparam tfl_byte_t ADDR_LOC_TEMP = 8'h0A;
  localparam tfl_byte_t ADDR_REM_TEMP = 8'h0B;
  localparam tfl_byte_t ADDR_LOC_OFS = 8'h0D;
  localparam tfl_byte_t ADDR_REM_OFS = 8'h0E;
  localparam tfl_byte_t ADDR_FAN_STALL = 8'h10;
  localparam tfl_byte_t ADDR_LOC_HIGH = 8'h14;
  localparam tfl_byte_t ADDR_LOC_LOW = 8'h15;
  localparam tfl_byte_t ADDR_LOC_ALARM = 8'h16;
  localparam tfl_byte_t ADDR_REM_HIGH = 8'h18;
  localparam tfl_byte_t ADDR_REM_LOW = 8'h19;
  localparam tfl_byte_t ADDR_REM_ALARM = 8'h1A;
  localparam tfl_byte_t ADDR_LOC_SD = 8'h1B;
  localparam tfl_byte_t ADDR_REM_SD = 8'h1C;
  // -------------------------------------------------------
  // Reset values
  // -------------------------------------------------------
  localparam tfl_byte_t RST_ZERO = 8'h00;
  localparam tfl_byte_t RST_TEMP = 8'h1E;
  localparam tfl_byte_t RST_ONES = 8'hFF;
  localparam tfl_byte_t RST_LOC_HIGH = 8'h3C;
  localparam tfl_byte_t RST_REM_HIGH = 8'h50;
  localparam tfl_byte_t RST_LOC_ALARM = 8'h46;
  localparam tfl_byte_t RST_REM_ALARM = 8'h64;
  localparam tfl_byte_t RST_LOC_SD = 8'h5F;
  localparam tfl_byte_t RST_REM_SD = 8'h7D;
  // Trip-select strap tables, one byte per pin code {b,a}
  localparam logic [31:0] TRIP_LOC_ALARM = 32'h5A50_4B46;
  localparam logic [31:0] TRIP_REM_ALARM = 32'h7D78_6E64;
  localparam logic [31:0] TRIP_LOC_SD = 32'h7D78_6E5F;
  localparam logic [31:0] TRIP_REM_SD = 32'h7F7D_787D;
  // -------------------------------------------------------
  // Status bit positions
  // -------------------------------------------------------
  localparam int ST_LOC_LOW = 7;
  localparam int ST_LOC_HIGH = 6;
  localparam int ST_REM_LOW = 3;
  localparam int ST_REM_HIGH = 2;
  // -------------------------------------------------------
  // Fan period timing
  // -------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TACH_TICK_NS = 10000;
  localparam int TACH_TICK_CYC = (TACH_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TACH_TICK_W = 10;
  localparam logic [TACH_TICK_W-1:0] TACH_TICK_LAST = TACH_TICK_W'(TACH_TICK_CYC - 1);
  // -------------------------------------------------------
  // Types
  // -------------------------------------------------------
  typedef struct packed {
    logic [7:0] whole;
    logic [2:0] frac;
  } tfl_temp_t;
  typedef struct packed {
    logic [2:0] local_frac;
    logic [1:0] unused;
    logic [2:0] remote_frac;
  } tfl_frac_reg_t;
  typedef struct packed {
    logic sign;
    logic [2:0] unused;
    logic [3:0] mag;
  } tfl_offset_t;
  typedef enum logic {TACH_IDLE = 1'b0, TACH_RUN = 1'b1} tfl_tach_state_t;
endpackage
`default_nettype wire

// file: verilog/tfl_regs.sv
// What this block does
// R1 - Fraction byte: local bits in [7:5], remote in [2:0], [4:3] read zero.
// R2 - Integer temperature bytes read-only, each resets to thirty degrees.
// R3 - Local offset magnitude added when sign clear, subtracted when set.
// R4 - Remote offset magnitude applied the same signed way.
// R5 - Offset bits [6:4] always read back zero.
// R6 - Read-only fan period reading, resets to all ones.
// R7 - Fan stalled when period reading exceeds stall limit; limit resets to all ones.
// R8 - Local high/low limits writable, reset to sixty and zero degrees.
// R9 - Remote high/low limits writable, reset to eighty and zero degrees.
// R10 - Local alarm limit drives thermal alarm, default seventy or strap value.
// R11 - Remote alarm limit drives thermal alarm, default one hundred or strap value.
// R12 - Local shutdown limit drives local shutdown, default ninety-five or strap.
// R13 - Remote shutdown limit drives remote shutdown, default 125 or strap.
// R14 - Local-high status flag set on exceed, cleared by status read, re-sets.
// R15 - Integer temperatures and temperature limits are one degree per bit; the fan stall limit is in fan period ticks.
// R16 - Limits are compared against offset-corrected temperatures.
`timescale 1ns/10ps
`default_nettype none
module tfl_regs #(
  parameter bit TRIP_PINS_EN = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic meas_valid_in,
  input wire tfl_pkg::tfl_temp_t local_raw_in,
  input wire tfl_pkg::tfl_temp_t remote_raw_in,
  input wire logic fan_tach_in,
  input wire logic trip_select_pin_a_in,
  input wire logic trip_select_pin_b_in,
  output logic [7:0] reg_rdata_out,
  output logic thermal_alarm_out,
  output logic local_shutdown_out,
  output logic remote_shutdown_out,
  output logic fan_stall_out
);
  // -------------------------------------------------------
  // Helpers
  // -------------------------------------------------------
  function automatic logic [7:0] apply_offset(input logic [7:0] t, input tfl_pkg::tfl_offset_t o);
    logic signed [9:0] s;
    s = 10'(signed'(t));
    s = o.sign ? s - 10'(o.mag) : s + 10'(o.mag);
    if (s > 10'sd127)
      return 8'h7F;
    if (s < -10'sd128)
      return 8'h80;
    return s[7:0];
  endfunction

  function automatic logic gt(input logic [7:0] a, input logic [7:0] b);
    return signed'(a) > signed'(b);
  endfunction

  function automatic logic [7:0] pick(input logic [31:0] tab, input logic [1:0] code);
    return tab[8*code +: 8];
  endfunction

  function automatic logic wr_hit(input logic [7:0] a);
    return ce_in && reg_wr_in && (reg_addr_in == a);
  endfunction

  // -------------------------------------------------------
  // State
  // -------------------------------------------------------
  logic [7:0] loc_int_ff, rem_int_ff;
  tfl_pkg::tfl_frac_reg_t frac_ff;
  tfl_pkg::tfl_offset_t loc_ofs_ff, rem_ofs_ff;
  logic [7:0] fan_period_ff, fan_limit_ff;
  logic [7:0] loc_high_ff, loc_low_ff, rem_high_ff, rem_low_ff;
  logic [7:0] loc_alarm_ff, rem_alarm_ff, loc_sd_ff, rem_sd_ff;
  logic [7:0] status_ff;
  logic [2:0] tach_sync_ff;
  logic tach_filt_ff;
  logic [2:0] pin_a_sync_ff, pin_b_sync_ff;
  logic strap_done_ff;
  logic [1:0] strap_fill_ff;
  logic [tfl_pkg::TACH_TICK_W-1:0] tick_cnt_ff;
  logic [7:0] period_cnt_ff;
  tfl_pkg::tfl_tach_state_t tach_state_ff;

  // -------------------------------------------------------
  // Decode
  // -------------------------------------------------------
  wire tfl_pkg::tfl_offset_t wr_ofs = '{sign: reg_wdata_in[7], unused: 3'h0, mag: reg_wdata_in[3:0]};
  wire [7:0] nxt_loc_int = apply_offset(local_raw_in.whole, loc_ofs_ff); // [R3]
  wire [7:0] nxt_rem_int = apply_offset(remote_raw_in.whole, rem_ofs_ff); // [R4]
  wire tfl_pkg::tfl_frac_reg_t nxt_frac = '{local_frac: local_raw_in.frac, unused: 2'h0,
                                           remote_frac: remote_raw_in.frac}; // [R1]
  wire status_rd = ce_in && reg_rd_in && (reg_addr_in == tfl_pkg::ADDR_STATUS);
  wire loc_high_hit = gt(loc_int_ff, loc_high_ff); // [R16]
  wire loc_low_hit = gt(loc_low_ff, loc_int_ff);
  wire rem_high_hit = gt(rem_int_ff, rem_high_ff);
  wire rem_low_hit = gt(rem_low_ff, rem_int_ff);
  wire [7:0] status_set = (8'(loc_low_hit) << tfl_pkg::ST_LOC_LOW) | (8'(loc_high_hit) << tfl_pkg::ST_LOC_HIGH)
                        | (8'(rem_low_hit) << tfl_pkg::ST_REM_LOW) | (8'(rem_high_hit) << tfl_pkg::ST_REM_HIGH);
  wire [7:0] nxt_status = (status_rd ? 8'h00 : status_ff) | status_set; // [R14]
  wire pins_settled = (pin_a_sync_ff[1] == pin_a_sync_ff[2]) && (pin_b_sync_ff[1] == pin_b_sync_ff[2]);
  wire strap_load = TRIP_PINS_EN && !strap_done_ff && pins_settled && (&strap_fill_ff);
  wire [1:0] trip_code = {pin_b_sync_ff[2], pin_a_sync_ff[2]};
  wire tach_agree = tach_sync_ff[1] == tach_sync_ff[2];
  wire tach_rise = tach_agree && tach_sync_ff[1] && !tach_filt_ff;
  wire tick = tick_cnt_ff == tfl_pkg::TACH_TICK_LAST;
  wire period_sat = period_cnt_ff == tfl_pkg::RST_ONES;
  wire [7:0] rd_mux =
    (reg_addr_in == tfl_pkg::ADDR_STATUS) ? status_ff :
    (reg_addr_in == tfl_pkg::ADDR_FRAC) ? frac_ff :
    (reg_addr_in == tfl_pkg::ADDR_FAN_PERIOD) ? fan_period_ff :
    (reg_addr_in == tfl_pkg::ADDR_LOC_TEMP) ? loc_int_ff :
    (reg_addr_in == tfl_pkg::ADDR_REM_TEMP) ? rem_int_ff :
    (reg_addr_in == tfl_pkg::ADDR_LOC_OFS) ? loc_ofs_ff :
    (reg_addr_in == tfl_pkg::ADDR_REM_OFS) ? rem_ofs_ff :
    (reg_addr_in == tfl_pkg::ADDR_FAN_STALL) ? fan_limit_ff :
    (reg_addr_in == tfl_pkg::ADDR_LOC_HIGH) ? loc_high_ff :
    (reg_addr_in == tfl_pkg::ADDR_LOC_LOW) ? loc_low_ff :
    (reg_addr_in == tfl_pkg::ADDR_LOC_ALARM) ? loc_alarm_ff :
    (reg_addr_in == tfl_pkg::ADDR_REM_HIGH) ? rem_high_ff :
    (reg_addr_in == tfl_pkg::ADDR_REM_LOW) ? rem_low_ff :
    (reg_addr_in == tfl_pkg::ADDR_REM_ALARM) ? rem_alarm_ff :
    (reg_addr_in == tfl_pkg::ADDR_LOC_SD) ? loc_sd_ff :
    (reg_addr_in == tfl_pkg::ADDR_REM_SD) ? rem_sd_ff : tfl_pkg::RST_ZERO;

  // -------------------------------------------------------
  // Measurements and status
  // -------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      loc_int_ff <= tfl_pkg::RST_TEMP; // [R2]
      rem_int_ff <= tfl_pkg::RST_TEMP; // [R2]
      frac_ff <= '0;
      status_ff <= tfl_pkg::RST_ZERO;
      reg_rdata_out <= tfl_pkg::RST_ZERO;
    end
    else if (ce_in)
    begin
      if (meas_valid_in)
      begin
        loc_int_ff <= nxt_loc_int; // [R15]
        rem_int_ff <= nxt_rem_int;
        frac_ff <= nxt_frac;
      end
      status_ff <= nxt_status;
      if (reg_rd_in)
        reg_rdata_out <= rd_mux;
    end
  end

  // -------------------------------------------------------
  // Writable registers
  // -------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      loc_ofs_ff <= '0;
      rem_ofs_ff <= '0;
      fan_limit_ff <= tfl_pkg::RST_ONES; // [R7]
      loc_high_ff <= tfl_pkg::RST_LOC_HIGH; // [R8]
      loc_low_ff <= tfl_pkg::RST_ZERO; // [R8]
      rem_high_ff <= tfl_pkg::RST_REM_HIGH; // [R9]
      rem_low_ff <= tfl_pkg::RST_ZERO; // [R9]
    end
    else
    begin
      if (wr_hit(tfl_pkg::ADDR_LOC_OFS))
        loc_ofs_ff <= wr_ofs; // [R5]
      if (wr_hit(tfl_pkg::ADDR_REM_OFS))
        rem_ofs_ff <= wr_ofs; // [R5]
      if (wr_hit(tfl_pkg::ADDR_FAN_STALL))
        fan_limit_ff <= reg_wdata_in;
      if (wr_hit(tfl_pkg::ADDR_LOC_HIGH))
        loc_high_ff <= reg_wdata_in;
      if (wr_hit(tfl_pkg::ADDR_LOC_LOW))
        loc_low_ff <= reg_wdata_in;
      if (wr_hit(tfl_pkg::ADDR_REM_HIGH))
        rem_high_ff <= reg_wdata_in;
      if (wr_hit(tfl_pkg::ADDR_REM_LOW))
        rem_low_ff <= reg_wdata_in;
    end
  end

  // -------------------------------------------------------
  // Critical limits with strap defaults
  // -------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      loc_alarm_ff <= tfl_pkg::RST_LOC_ALARM; // [R10]
      rem_alarm_ff <= tfl_pkg::RST_REM_ALARM; // [R11]
      loc_sd_ff <= tfl_pkg::RST_LOC_SD; // [R12]
      rem_sd_ff <= tfl_pkg::RST_REM_SD; // [R13]
      strap_done_ff <= 1'b0;
      strap_fill_ff <= '0;
      pin_a_sync_ff <= 3'h0;
      pin_b_sync_ff <= 3'h0;
    end
    else if (ce_in)
    begin
      pin_a_sync_ff <= {pin_a_sync_ff[1:0], trip_select_pin_a_in};
      pin_b_sync_ff <= {pin_b_sync_ff[1:0], trip_select_pin_b_in};
      strap_fill_ff <= strap_fill_ff + {1'b0, !(&strap_fill_ff)};
      if (pins_settled && (&strap_fill_ff))
        strap_done_ff <= 1'b1;
      if (strap_load)
      begin
        loc_alarm_ff <= pick(tfl_pkg::TRIP_LOC_ALARM, trip_code); // [R10]
        rem_alarm_ff <= pick(tfl_pkg::TRIP_REM_ALARM, trip_code); // [R11]
        loc_sd_ff <= pick(tfl_pkg::TRIP_LOC_SD, trip_code); // [R12]
        rem_sd_ff <= pick(tfl_pkg::TRIP_REM_SD, trip_code); // [R13]
      end
      else
      begin
        if (wr_hit(tfl_pkg::ADDR_LOC_ALARM))
          loc_alarm_ff <= reg_wdata_in;
        if (wr_hit(tfl_pkg::ADDR_REM_ALARM))
          rem_alarm_ff <= reg_wdata_in;
        if (wr_hit(tfl_pkg::ADDR_LOC_SD))
          loc_sd_ff <= reg_wdata_in;
        if (wr_hit(tfl_pkg::ADDR_REM_SD))
          rem_sd_ff <= reg_wdata_in;
      end
    end
  end

  // -------------------------------------------------------
  // Fan period measurement
  // -------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      tach_sync_ff <= 3'h0;
      tach_filt_ff <= 1'b0;
      tick_cnt_ff <= '0;
      period_cnt_ff <= tfl_pkg::RST_ZERO;
      fan_period_ff <= tfl_pkg::RST_ONES; // [R6]
      tach_state_ff <= tfl_pkg::TACH_IDLE;
    end
    else if (ce_in)
    begin
      tach_sync_ff <= {tach_sync_ff[1:0], fan_tach_in};
      if (tach_agree)
        tach_filt_ff <= tach_sync_ff[1];
      tick_cnt_ff <= (tick || tach_rise) ? '0 : tick_cnt_ff + 1'b1;
      case (tach_state_ff)
        tfl_pkg::TACH_IDLE:
        begin
          if (tach_rise)
          begin
            period_cnt_ff <= tfl_pkg::RST_ZERO;
            tach_state_ff <= tfl_pkg::TACH_RUN;
          end
        end
        tfl_pkg::TACH_RUN:
        begin
          if (tach_rise)
          begin
            fan_period_ff <= period_cnt_ff; // [R6]
            period_cnt_ff <= tfl_pkg::RST_ZERO;
          end
          else if (period_sat)
            fan_period_ff <= tfl_pkg::RST_ONES; // [R6]
          else if (tick)
            period_cnt_ff <= period_cnt_ff + 1'b1;
        end
        default:
          tach_state_ff <= tfl_pkg::TACH_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------
  // Alarm outputs
  // -------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      thermal_alarm_out <= 1'b0;
      local_shutdown_out <= 1'b0;
      remote_shutdown_out <= 1'b0;
      fan_stall_out <= 1'b0;
    end
    else if (ce_in)
    begin
      thermal_alarm_out <= gt(loc_int_ff, loc_alarm_ff) || gt(rem_int_ff, rem_alarm_ff); // [R10] [R11]
      local_shutdown_out <= gt(loc_int_ff, loc_sd_ff); // [R12]
      remote_shutdown_out <= gt(rem_int_ff, rem_sd_ff); // [R13]
      fan_stall_out <= fan_period_ff > fan_limit_ff; // [R7]
    end
  end

  // -------------------------------------------------------
  // Assertions
  // -------------------------------------------------------
  property p_frac_mid_zero;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && reg_rd_in && reg_addr_in == tfl_pkg::ADDR_FRAC |=> reg_rdata_out[4:3] == 2'h0;
  endproperty
  a_frac_mid_zero: assert property (p_frac_mid_zero) else $error("fraction middle bits not zero"); // [R1]

  property p_temp_reset;
    @(posedge clk_in) $fell(rst_in) |-> loc_int_ff == tfl_pkg::RST_TEMP && rem_int_ff == tfl_pkg::RST_TEMP
      && fan_period_ff == tfl_pkg::RST_ONES;
  endproperty
  a_temp_reset: assert property (p_temp_reset) else $error("reading reset value wrong"); // [R2]

  property p_loc_offset;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && meas_valid_in |=> loc_int_ff == apply_offset($past(local_raw_in.whole), $past(loc_ofs_ff));
  endproperty
  a_loc_offset: assert property (p_loc_offset) else $error("local offset not applied"); // [R3]

  property p_rem_offset;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && meas_valid_in && !rem_ofs_ff.sign && remote_raw_in.whole < 8'h70
      |=> rem_int_ff == $past(remote_raw_in.whole) + 8'($past(rem_ofs_ff.mag));
  endproperty
  a_rem_offset: assert property (p_rem_offset) else $error("remote offset not applied"); // [R4]

  property p_ofs_read_zero;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && reg_rd_in && (reg_addr_in == tfl_pkg::ADDR_LOC_OFS || reg_addr_in == tfl_pkg::ADDR_REM_OFS)
      |=> reg_rdata_out[6:4] == 3'h0;
  endproperty
  a_ofs_read_zero: assert property (p_ofs_read_zero) else $error("offset unused bits not zero"); // [R5]

  property p_stall;
    @(posedge clk_in) disable iff (rst_in)
    ce_in |=> fan_stall_out == ($past(fan_period_ff) > $past(fan_limit_ff));
  endproperty
  a_stall: assert property (p_stall) else $error("stall flag wrong"); // [R7]

  property p_alarm;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && gt(rem_int_ff, rem_alarm_ff) |=> thermal_alarm_out;
  endproperty
  a_alarm: assert property (p_alarm) else $error("thermal alarm missing"); // [R11]

  property p_loc_sd;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && !gt(loc_int_ff, loc_sd_ff) |=> !local_shutdown_out;
  endproperty
  a_loc_sd: assert property (p_loc_sd) else $error("local shutdown spurious"); // [R12]

  property p_rem_sd;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && gt(rem_int_ff, rem_sd_ff) |=> remote_shutdown_out;
  endproperty
  a_rem_sd: assert property (p_rem_sd) else $error("remote shutdown missing"); // [R13]

  property p_high_flag;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && loc_high_hit |=> status_ff[tfl_pkg::ST_LOC_HIGH];
  endproperty
  a_high_flag: assert property (p_high_flag) else $error("local high flag lost"); // [R14]

  c_status_read: cover property (@(posedge clk_in) status_rd && status_ff[tfl_pkg::ST_LOC_HIGH]);
  c_stall: cover property (@(posedge clk_in) $rose(fan_stall_out));
  c_shutdown: cover property (@(posedge clk_in) $rose(local_shutdown_out));
endmodule // tfl_regs
`default_nettype wire

// file: test/tfl_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Register host; released lines show the inverse of their last value
module tfl_host_model (
  input wire logic clk_in,
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_wdata_out
);
  initial
  begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 8'h00;
  end
  // Strobes stay up between back-to-back calls
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    reg_addr_out = a;
    reg_wr_out = w;
    reg_rd_out = r;
    reg_wdata_out = d;
  endtask
  task automatic idle();
    @(posedge clk_in);
    #1;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = ~reg_addr_out;
    reg_wdata_out = ~reg_wdata_out;
  endtask
endmodule // tfl_host_model
`default_nettype wire

// file: test/tfl_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tfl_regs_tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic meas_valid = 1'b0;
  tfl_pkg::tfl_temp_t local_raw = '0;
  tfl_pkg::tfl_temp_t remote_raw = '0;
  logic fan_tach = 1'b0;
  logic pin_a = 1'b0;
  logic pin_b = 1'b0;
  wire logic [7:0] addr;
  wire logic [7:0] wdata;
  wire logic [7:0] rdata;
  wire logic wr;
  wire logic rd;
  wire logic alarm;
  wire logic lsd;
  wire logic rsd;
  wire logic stall;
  int miscompares = 0;
  int n_tests = 0;
  int seed = 32'h40a3d92b;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [7:0] frac_exp;
  logic [7:0] vals [15];
  logic [7:0] l, r, lo, ro, st;
  localparam logic [7:0] RA [15] = '{8'h06, 8'h08, 8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h10, 8'h14, 8'h15,
    8'h16, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C};
  localparam logic [7:0] RV [15] = '{8'h00, 8'hFF, 8'h1E, 8'h1E, 8'h00, 8'h00, 8'hFF, 8'h3C, 8'h00,
    8'h46, 8'h50, 8'h00, 8'h64, 8'h5F, 8'h7D};
  // Local, remote, offsets, expected {alarm, local shutdown, remote shutdown}
  localparam logic [39:0] ROWS [9] = '{40'h46_64_00_00_00, 40'h47_64_00_00_04, 40'h1E_65_00_00_04,
    40'h5F_7D_00_00_04, 40'h60_7E_00_00_07, 40'h45_1E_02_00_04, 40'h61_1E_82_00_04,
    40'h1E_7F_00_81_05, 40'h7A_1E_0F_00_06};

  tfl_host_model host (.clk_in(clk_in), .reg_addr_out(addr), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_wdata_out(wdata));
  tfl_regs dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wdata), .meas_valid_in(meas_valid), .local_raw_in(local_raw),
    .remote_raw_in(remote_raw), .fan_tach_in(fan_tach), .trip_select_pin_a_in(pin_a),
    .trip_select_pin_b_in(pin_b), .reg_rdata_out(rdata), .thermal_alarm_out(alarm),
    .local_shutdown_out(lsd), .remote_shutdown_out(rsd), .fan_stall_out(stall));

  initial
  begin
    forever #5 clk_in = ~clk_in;
  end

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Read data stands from the accepted read edge; look mid-cycle
  always @(posedge clk_in)
  begin
    rd_seen <= rd && ce_in && !rst_in;
  end

  always @(negedge clk_in)
  begin
    if (rd_seen)
      check(rdata, exp_q.pop_front());
  end

  initial
  begin
    #200000;
    miscompares++;
    results();
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.op(1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    host.op(1'b1, 1'b0, a, d);
  endtask

  task automatic meas(input logic [7:0] lt, input logic [7:0] rt);
    logic [2:0] lf;
    logic [2:0] rf;
    lf = 3'($random(seed));
    rf = 3'($random(seed));
    @(posedge clk_in);
    #1;
    local_raw = {lt, lf};
    remote_raw = {rt, rf};
    frac_exp = {lf, 2'b00, rf};
    {pin_b, pin_a} = 2'($random(seed));
    meas_valid = 1'b1;
    @(posedge clk_in);
    #1;
    meas_valid = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask

  task automatic setm(input logic [7:0] lt, input logic [7:0] rt, input logic [7:0] lof,
    input logic [7:0] rof);
    wr_reg(8'h0D, lof);
    wr_reg(8'h0E, rof);
    host.idle();
    meas(lt, rt);
  endtask

  initial
  begin
    repeat (6) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    for (int i = 0; i < 15; i++)
      rdx(RA[i], RV[i]);
    rdx(8'h30, 8'h00);
    host.idle();
    check({4'h0, alarm, lsd, rsd, stall}, 8'h00);
    ce_in = 1'b0;
    wr_reg(8'h14, 8'h11);
    host.idle();
    ce_in = 1'b1;
    rdx(8'h14, 8'h3C);
    wr_reg(8'h10, 8'hFE);
    host.idle();
    repeat (3) @(posedge clk_in);
    #1;
    check({7'h0, stall}, 8'h01);
    wr_reg(8'h10, 8'hFF);
    host.idle();
    repeat (3) @(posedge clk_in);
    #1;
    check({7'h0, stall}, 8'h00);
    repeat (6)
    begin
      #80 fan_tach = 1'b1;
      #80 fan_tach = 1'b0;
    end
    repeat (10) @(posedge clk_in);
    rdx(8'h08, 8'h00);
    wr_reg(8'h10, 8'h00);
    host.idle();
    repeat (3) @(posedge clk_in);
    #1;
    check({7'h0, stall}, 8'h00);
    for (int i = 4; i < 15; i++)
    begin
      vals[i] = 8'($random(seed));
      wr_reg(RA[i], vals[i]);
      rdx(RA[i], (i < 6) ? (vals[i] & 8'h8F) : vals[i]);
    end
    wr_reg(8'h0A, 8'h55);
    wr_reg(8'h30, 8'h55);
    rdx(8'h0A, 8'h1E);
    rdx(8'h30, 8'h00);
    for (int i = 4; i < 15; i++)
      wr_reg(RA[i], RV[i]);
    st = {$signed(vals[8]) > $signed(8'h1E), $signed(vals[7]) < $signed(8'h1E), 2'b00,
      $signed(vals[11]) > $signed(8'h1E), $signed(vals[10]) < $signed(8'h1E), 2'b00};
    rdx(8'h02, st);
    host.idle();
    for (int k = 0; k < 8; k++)
    begin
      l = 8'd20 + 8'($random(seed) & 63);
      r = 8'd20 + 8'($random(seed) & 63);
      lo = 8'($random(seed));
      ro = 8'($random(seed));
      setm(l, r, lo, ro);
      rdx(8'h0A, lo[7] ? l - {4'h0, lo[3:0]} : l + {4'h0, lo[3:0]});
      rdx(8'h0B, ro[7] ? r - {4'h0, ro[3:0]} : r + {4'h0, ro[3:0]});
      rdx(8'h06, frac_exp);
      rdx(8'h0E, ro & 8'h8F);
      host.idle();
    end
    for (int k = 0; k < 9; k++)
    begin
      setm(ROWS[k][39:32], ROWS[k][31:24], ROWS[k][23:16], ROWS[k][15:8]);
      check({5'h0, alarm, lsd, rsd}, ROWS[k][7:0]);
    end
    rdx(8'h0A, 8'h7F);
    host.idle();
    setm(8'h1E, 8'h1E, 8'h00, 8'h00);
    rdx(8'h02, 8'h44);
    rdx(8'h02, 8'h00);
    host.idle();
    setm(8'h3D, 8'h1E, 8'h00, 8'h00);
    rdx(8'h02, 8'h40);
    rdx(8'h02, 8'h40);
    host.idle();
    setm(8'h1E, 8'h1E, 8'h00, 8'h00);
    rdx(8'h02, 8'h40);
    rdx(8'h02, 8'h00);
    host.idle();
    repeat (3) @(posedge clk_in);
    results();
  end
endmodule // tfl_regs_tb
`default_nettype wire
